// ---- hw/rps_defines.vh ----
// register map, field positions, reset values and timing counts of the sequencer
`ifndef RPS_DEFINES_VH
`define RPS_DEFINES_VH
`define RPS_CLK_MHZ 250
`define RPS_I2C_ADDR 7'h48
`define RPS_REG_STATUS 8'h08
`define RPS_REG_ILIM 8'h20
`define RPS_REG_THR_A 8'h22
`define RPS_REG_THR_B 8'h26
`define RPS_REG_THR_C 8'h28
`define RPS_REG_FREQ 8'h2a
`define RPS_REG_LDO 8'h2b
`define RPS_REG_EN_CTL 8'h32
`define RPS_REG_SEQ0 8'h40
`define RPS_REG_SEQ1 8'h41
`define RPS_REG_SEQ2 8'h42
`define RPS_RST_ILIM 8'h03
`define RPS_RST_THR 8'h20
`define RPS_RST_FREQ 8'h00
`define RPS_RST_LDO 8'h42
`define RPS_RST_EN_CTL 8'h00
`define RPS_RST_SEQ 8'h00
`define RPS_EN_BIT 7
`define RPS_UV_LSB 2
`define RPS_OV_LSB 4
`define RPS_FREQ_LSB 0
`define RPS_ILIM_A_LSB 6
`define RPS_ILIM_B_LSB 2
`define RPS_ILIM_C_LSB 0
`define RPS_LDOH_LSB 6
`define RPS_LDOL_LSB 1
`define RPS_SEQ_DLY_LSB 4
`define RPS_MGMT_READY_US 10
`define RPS_LDO_HIGH_READY_US 8
`define RPS_LDO_LOW_READY_US 8
`define RPS_PG_RELEASE_MS 60
`define RPS_STEP_UNIT_US 100
`define RPS_MGMT_CYC (`RPS_MGMT_READY_US * `RPS_CLK_MHZ)
`define RPS_LDOH_CYC (`RPS_LDO_HIGH_READY_US * `RPS_CLK_MHZ)
`define RPS_LDOL_CYC (`RPS_LDO_LOW_READY_US * `RPS_CLK_MHZ)
`define RPS_PG_RELEASE_CYC (`RPS_PG_RELEASE_MS * 1000 * `RPS_CLK_MHZ)
`define RPS_STEP_UNIT_CYC (`RPS_STEP_UNIT_US * `RPS_CLK_MHZ)
`endif

// ---- hw/rps_i2c_target.v ----
// byte-level management bus target: pointer write, data write, auto-incrementing read
`timescale 1ns/10ps
`default_nettype none
`include "rps_defines.vh"
module rps_i2c_target (
  input  wire       i_mclk,
  input  wire       i_rst,
  input  wire       i_scl,
  input  wire       i_sda,
  input  wire       i_enable,
  input  wire       i_nack_all,
  input  wire [7:0] i_rd_data,
  output reg        o_sda_oe,
  output reg  [7:0] o_addr,
  output reg        o_wr_stb,
  output reg  [7:0] o_wr_data
);
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ACKA = 3'd2;
  localparam S_WR   = 3'd3;
  localparam S_ACKW = 3'd4;
  localparam S_RD   = 3'd5;
  localparam S_RACK = 3'd6;
  localparam S_RNXT = 3'd7;

  reg [1:0] s1, s2, s3, filt, prev;
  reg [2:0] st;
  reg [3:0] bitc;
  reg [7:0] sh;
  reg       rw;
  reg       ptr_ok;
  wire      scl = filt[1];
  wire      sda = filt[0];
  wire      scl_rise = scl & ~prev[1];
  wire      scl_fall = ~scl & prev[1];
  wire      start = scl & prev[1] & ~sda & prev[0];
  wire      stop = scl & prev[1] & sda & ~prev[0];

  // a level change counts only once the second and third stages agree
  always @(posedge i_mclk) begin
    if (i_rst) begin
      s1   <= 2'h3;
      s2   <= 2'h3;
      s3   <= 2'h3;
      filt <= 2'h3;
      prev <= 2'h3;
    end else begin
      s1   <= {i_scl, i_sda};
      s2   <= s1;
      s3   <= s2;
      filt <= (s2 & s3) | (filt & (s2 ^ s3));
      prev <= filt;
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      st        <= S_IDLE;
      bitc      <= 4'h0;
      sh        <= 8'h00;
      rw        <= 1'b0;
      ptr_ok    <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_addr    <= 8'h00;
      o_wr_stb  <= 1'b0;
      o_wr_data <= 8'h00;
    end else begin
      o_wr_stb <= 1'b0;
      if (o_wr_stb) begin
        o_addr <= o_addr + 8'h01;
      end
      if (start) begin
        st       <= S_ADDR;
        bitc     <= 4'h0;
        ptr_ok   <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop) begin
        st       <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (st)
          S_ADDR, S_WR: begin
            sh   <= {sh[6:0], sda};
            bitc <= bitc + 4'h1;
          end
          S_RD: bitc <= bitc + 4'h1;
          S_RACK: begin
            if (sda) begin
              st <= S_IDLE;
            end else begin
              o_addr <= o_addr + 8'h01;
              st     <= S_RNXT;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st)
          S_ADDR: begin
            if (bitc == 4'h8) begin
              // busy sequencer or interface not yet up: stay off the bus, master sees NACK
              if (sh[7:1] == `RPS_I2C_ADDR && i_enable && !i_nack_all) begin
                o_sda_oe <= 1'b1;
                rw       <= sh[0];
                st       <= S_ACKA;
              end else begin
                st <= S_IDLE;
              end
            end
          end
          S_ACKA: begin
            bitc <= 4'h0;
            if (rw) begin
              sh       <= i_rd_data;
              o_sda_oe <= ~i_rd_data[7];
              st       <= S_RD;
            end else begin
              o_sda_oe <= 1'b0;
              st       <= S_WR;
            end
          end
          S_WR: begin
            if (bitc == 4'h8) begin
              if (i_nack_all) begin
                st <= S_IDLE;
              end else begin
                o_sda_oe <= 1'b1;
                st       <= S_ACKW;
                if (!ptr_ok) begin
                  o_addr <= sh;
                end
                o_wr_data <= sh;
              end
            end
          end
          S_ACKW: begin
            o_sda_oe <= 1'b0;
            o_wr_stb <= ptr_ok;
            ptr_ok   <= 1'b1;
            bitc     <= 4'h0;
            st       <= S_WR;
          end
          S_RD: begin
            if (bitc == 4'h8) begin
              o_sda_oe <= 1'b0;
              st       <= S_RACK;
            end else begin
              o_sda_oe <= ~sh[3'd7 - bitc[2:0]];
            end
          end
          S_RNXT: begin
            sh       <= i_rd_data;
            o_sda_oe <= ~i_rd_data[7];
            bitc     <= 4'h0;
            st       <= S_RD;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // rps_i2c_target
`default_nettype wire

// ---- hw/rps_sequencer.v ----
// power-up and enable sequencer with configuration decode and management registers
`timescale 1ns/10ps
`default_nettype none
`include "rps_defines.vh"
module rps_sequencer #(
  parameter [31:0] P_RELEASE_CYC   = `RPS_PG_RELEASE_CYC,
  parameter [31:0] P_STEP_UNIT_CYC = `RPS_STEP_UNIT_CYC
) (
  input  wire       i_mclk,
  input  wire       i_rst,
  input  wire       i_supply_ok,
  input  wire       i_enable_pin,
  input  wire       i_power_ok_in,
  output wire       o_power_ok_out,
  output reg        o_power_ok_oe,
  input  wire       i_scl,
  input  wire       i_sda_in,
  output wire       o_sda_out,
  output wire       o_sda_oe,
  input  wire       i_ldo_high_ok,
  input  wire       i_ldo_low_ok,
  input  wire [2:0] i_buck_ok,
  output reg        o_ldo_high_en,
  output reg        o_ldo_low_en,
  output reg  [2:0] o_buck_en,
  output reg        o_mgmt_ready,
  output reg  [7:0] o_buck_a_uv,
  output reg  [7:0] o_buck_b_uv,
  output reg  [7:0] o_buck_c_uv,
  output reg  [7:0] o_buck_a_ov,
  output reg  [7:0] o_buck_b_ov,
  output reg  [7:0] o_buck_c_ov,
  output reg  [7:0] o_buck_c_freq,
  output reg  [7:0] o_buck_a_ilim,
  output reg  [7:0] o_buck_b_ilim,
  output reg  [7:0] o_buck_c_ilim,
  output reg  [7:0] o_ldo_high_volt,
  output reg  [7:0] o_ldo_low_volt
);
  localparam S_OFF   = 4'd0;
  localparam S_WAIT  = 4'd1;
  localparam S_CHECK = 4'd2;
  localparam S_STEP  = 4'd3;
  localparam S_DELAY = 4'd4;
  localparam S_LOAD  = 4'd5;
  localparam S_RAILS = 4'd6;
  localparam S_DONE  = 4'd7;
  localparam S_FAULT = 4'd8;
  localparam [31:0] MGMT_CYC = `RPS_MGMT_CYC;
  localparam [31:0] LDOH_CYC = `RPS_LDOH_CYC;
  localparam [31:0] LDOL_CYC = `RPS_LDOL_CYC;

  // under-voltage in tenths of a percent below target
  function [7:0] rps_uv_dec;
    input [1:0] c;
    case (c)
      2'b00:   rps_uv_dec = 8'd100;
      2'b01:   rps_uv_dec = 8'd125;
      2'b10:   rps_uv_dec = 8'd75;
      default: rps_uv_dec = 8'd200;
    endcase
  endfunction

  // over-voltage in tenths of a percent above target
  function [7:0] rps_ov_dec;
    input [1:0] c;
    case (c)
      2'b00:   rps_ov_dec = 8'd75;
      2'b01:   rps_ov_dec = 8'd100;
      2'b10:   rps_ov_dec = 8'd125;
      default: rps_ov_dec = 8'd200;
    endcase
  endfunction

  // valley limit in tenths of an ampere; code 11 is reserved and held at the top step
  function [7:0] rps_ilim_ab_dec;
    input [1:0] c;
    case (c)
      2'b00:   rps_ilim_ab_dec = 8'd50;
      2'b01:   rps_ilim_ab_dec = 8'd55;
      default: rps_ilim_ab_dec = 8'd60;
    endcase
  endfunction

  // ldo output in units of 10 mV: base plus 100 mV per code step
  function [7:0] rps_ldo_dec;
    input [7:0] base;
    input [1:0] c;
    rps_ldo_dec = base + 8'd10 * {6'd0, c};
  endfunction

  reg  [7:0]  s1;
  reg  [7:0]  s2;
  reg  [7:0]  s3;
  reg  [7:0]  filt;
  reg  [7:0]  r_ilim;
  reg  [7:0]  r_thr_a;
  reg  [7:0]  r_thr_b;
  reg  [7:0]  r_thr_c;
  reg  [7:0]  r_freq;
  reg  [7:0]  r_ldo;
  reg  [7:0]  r_en_ctl;
  reg  [7:0]  r_seq0;
  reg  [7:0]  r_seq1;
  reg  [7:0]  r_seq2;
  reg  [7:0]  rd_data;
  reg  [3:0]  st;
  reg  [1:0]  step;
  reg  [31:0] dly_cnt;
  reg  [31:0] rel_cnt;
  reg  [31:0] up_cnt;
  reg         pin_used;
  reg         pin_start;
  reg         seq_done;
  reg         tmo;
  reg         ldo_fault;
  reg         pok_rel;
  wire [7:0]  bus_addr;
  wire        bus_wr;
  wire [7:0]  bus_wdata;
  wire [7:0]  raw = {i_buck_ok, i_ldo_low_ok, i_ldo_high_ok, i_power_ok_in,
                     i_enable_pin, i_supply_ok};
  wire        supply_v = filt[0];
  wire        pin_v = filt[1];
  wire        pok_in = filt[2];
  wire        ldoh_ok = filt[3];
  wire        ldol_ok = filt[4];
  wire [2:0]  buck_ok = filt[7:5];
  wire        busy = (st >= S_CHECK) && (st <= S_RAILS);
  wire        running = st >= S_CHECK;
  wire [7:0]  cur = (step == 2'd0) ? r_seq0 : (step == 2'd1) ? r_seq1 : r_seq2;
  wire [31:0] step_cyc = {29'd0, cur[6:4]} * P_STEP_UNIT_CYC;
  wire        en_wr = bus_wr && (bus_addr == `RPS_REG_EN_CTL);
  wire        bus_en_set = en_wr && bus_wdata[`RPS_EN_BIT];
  wire        bus_en_clr = en_wr && !bus_wdata[`RPS_EN_BIT];
  wire        en_evt = (pin_v && !pin_used) || bus_en_set;
  wire        off_evt = (pin_start && !pin_v) || bus_en_clr;
  wire        rails_ok = ((buck_ok & o_buck_en) == o_buck_en) && ldoh_ok && ldol_ok
                         && !ldo_fault;
  wire [7:0]  status = {2'b00, pok_rel, ldo_fault, supply_v, seq_done, tmo, pok_in};

  assign o_power_ok_out = 1'b0;
  assign o_sda_out = 1'b0;

  // three stages; a level change counts only once the second and third agree
  always @(posedge i_mclk) begin
    if (i_rst) begin
      s1   <= 8'h00;
      s2   <= 8'h00;
      s3   <= 8'h00;
      filt <= 8'h00;
    end else begin
      s1   <= raw;
      s2   <= s1;
      s3   <= s2;
      filt <= (s2 & s3) | (filt & (s2 ^ s3));
    end
  end

  rps_i2c_target u_bus (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_scl      (i_scl),
    .i_sda      (i_sda_in),
    .i_enable   (o_mgmt_ready),
    .i_nack_all (busy),
    .i_rd_data  (rd_data),
    .o_sda_oe   (o_sda_oe),
    .o_addr     (bus_addr),
    .o_wr_stb   (bus_wr),
    .o_wr_data  (bus_wdata)
  );

  // register file; losing the supply is a power cycle and clears it like reset
  always @(posedge i_mclk) begin
    if (i_rst || !supply_v) begin
      r_ilim   <= `RPS_RST_ILIM;
      r_thr_a  <= `RPS_RST_THR;
      r_thr_b  <= `RPS_RST_THR;
      r_thr_c  <= `RPS_RST_THR;
      r_freq   <= `RPS_RST_FREQ;
      r_ldo    <= `RPS_RST_LDO;
      r_en_ctl <= `RPS_RST_EN_CTL;
      r_seq0   <= `RPS_RST_SEQ;
      r_seq1   <= `RPS_RST_SEQ;
      r_seq2   <= `RPS_RST_SEQ;
      rd_data  <= 8'h00;
    end else begin
      if (bus_wr) begin
        case (bus_addr)
          `RPS_REG_ILIM:   r_ilim <= bus_wdata;
          `RPS_REG_THR_A:  r_thr_a <= bus_wdata;
          `RPS_REG_THR_B:  r_thr_b <= bus_wdata;
          `RPS_REG_THR_C:  r_thr_c <= bus_wdata;
          `RPS_REG_FREQ:   r_freq <= bus_wdata;
          `RPS_REG_LDO:    r_ldo <= bus_wdata;
          `RPS_REG_EN_CTL: r_en_ctl <= bus_wdata;
          `RPS_REG_SEQ0:   r_seq0 <= bus_wdata;
          `RPS_REG_SEQ1:   r_seq1 <= bus_wdata;
          `RPS_REG_SEQ2:   r_seq2 <= bus_wdata;
          default: ;
        endcase
      end
      case (bus_addr)
        `RPS_REG_STATUS: rd_data <= status;
        `RPS_REG_ILIM:   rd_data <= r_ilim;
        `RPS_REG_THR_A:  rd_data <= r_thr_a;
        `RPS_REG_THR_B:  rd_data <= r_thr_b;
        `RPS_REG_THR_C:  rd_data <= r_thr_c;
        `RPS_REG_FREQ:   rd_data <= r_freq;
        `RPS_REG_LDO:    rd_data <= r_ldo;
        `RPS_REG_EN_CTL: rd_data <= r_en_ctl;
        `RPS_REG_SEQ0:   rd_data <= r_seq0;
        `RPS_REG_SEQ1:   rd_data <= r_seq1;
        `RPS_REG_SEQ2:   rd_data <= r_seq2;
        default:         rd_data <= 8'h00;
      endcase
    end
  end

  // supply-up timing: management ready and LDO deadlines share one counter
  always @(posedge i_mclk) begin
    if (i_rst || !supply_v) begin
      up_cnt        <= 32'd0;
      o_mgmt_ready  <= 1'b0;
      o_ldo_high_en <= 1'b0;
      o_ldo_low_en  <= 1'b0;
      ldo_fault     <= 1'b0;
    end else begin
      o_ldo_high_en <= 1'b1;
      o_ldo_low_en  <= 1'b1;
      if (up_cnt != 32'hffffffff) begin
        up_cnt <= up_cnt + 32'd1;
      end
      if (up_cnt >= MGMT_CYC - 32'd1) begin
        o_mgmt_ready <= 1'b1;
      end
      if ((up_cnt == LDOH_CYC && !ldoh_ok) || (up_cnt == LDOL_CYC && !ldol_ok)) begin
        ldo_fault <= 1'b1;
      end
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst || !supply_v) begin
      st        <= S_OFF;
      step      <= 2'd0;
      dly_cnt   <= 32'd0;
      rel_cnt   <= 32'd0;
      pin_used  <= 1'b0;
      pin_start <= 1'b0;
      seq_done  <= 1'b0;
      tmo       <= 1'b0;
      o_buck_en <= 3'b000;
    end else begin
      if (!pin_v) begin
        pin_used <= 1'b0;
      end
      if (busy) begin
        rel_cnt <= rel_cnt + 32'd1;
      end
      if (running && off_evt) begin
        st        <= S_WAIT;
        o_buck_en <= 3'b000;
        seq_done  <= 1'b0;
      end else if (busy && rel_cnt >= P_RELEASE_CYC - 32'd1) begin
        // abort leaves the bucks off and power_ok_od low; bus opens again for diagnosis
        st        <= S_FAULT;
        tmo       <= 1'b1;
        o_buck_en <= 3'b000;
      end else begin
        case (st)
          S_OFF: st <= S_WAIT;
          S_WAIT: begin
            // a pin already high at supply-up counts as an enable
            if (en_evt) begin
              st        <= S_CHECK;
              pin_start <= !bus_en_set;
              pin_used  <= pin_v;
              rel_cnt   <= 32'd0;
              tmo       <= 1'b0;
              step      <= 2'd0;
            end
          end
          S_CHECK: begin
            if (supply_v && !ldo_fault) begin
              st <= S_STEP;
            end
          end
          S_STEP: begin
            o_buck_en <= o_buck_en | cur[2:0];
            dly_cnt   <= 32'd0;
            st        <= S_DELAY;
          end
          S_DELAY: begin
            // the step delay starts only after every buck of the step is up
            if ((buck_ok & cur[2:0]) == cur[2:0]) begin
              dly_cnt <= dly_cnt + 32'd1;
              if (dly_cnt >= step_cyc) begin
                if (step == 2'd2) begin
                  st <= S_LOAD;
                end else begin
                  step <= step + 2'd1;
                  st   <= S_STEP;
                end
              end
            end
          end
          S_LOAD: st <= S_RAILS;
          S_RAILS: begin
            if (rails_ok) begin
              seq_done <= 1'b1;
              st       <= S_DONE;
            end
          end
          S_DONE: ;
          S_FAULT: ;
          default: st <= S_OFF;
        endcase
      end
    end
  end

  // pin is driven low from supply valid until a clean finish with both LDOs and every enabled buck in tolerance
  always @(posedge i_mclk) begin
    if (i_rst) begin
      pok_rel       <= 1'b0;
      o_power_ok_oe <= 1'b0;
    end else begin
      pok_rel       <= (st == S_DONE) && seq_done && rails_ok && supply_v;
      o_power_ok_oe <= supply_v && !((st == S_DONE) && seq_done && rails_ok);
    end
  end

  // active settings are taken from the registers only at the load step
  always @(posedge i_mclk) begin
    if (i_rst || !supply_v) begin
      o_buck_a_uv     <= rps_uv_dec(2'b00);
      o_buck_b_uv     <= rps_uv_dec(2'b00);
      o_buck_c_uv     <= rps_uv_dec(2'b00);
      o_buck_a_ov     <= rps_ov_dec(2'b10);
      o_buck_b_ov     <= rps_ov_dec(2'b10);
      o_buck_c_ov     <= rps_ov_dec(2'b10);
      o_buck_c_freq   <= 8'd75;
      o_buck_a_ilim   <= rps_ilim_ab_dec(2'b00);
      o_buck_b_ilim   <= rps_ilim_ab_dec(2'b00);
      o_buck_c_ilim   <= 8'd20;
      o_ldo_high_volt <= rps_ldo_dec(8'd170, 2'b01);
      o_ldo_low_volt  <= rps_ldo_dec(8'd90, 2'b01);
    end else if (st == S_LOAD) begin
      o_buck_a_uv   <= rps_uv_dec(r_thr_a[`RPS_UV_LSB +: 2]);
      o_buck_b_uv   <= rps_uv_dec(r_thr_b[`RPS_UV_LSB +: 2]);
      o_buck_c_uv   <= rps_uv_dec(r_thr_c[`RPS_UV_LSB +: 2]);
      o_buck_a_ov   <= rps_ov_dec(r_thr_a[`RPS_OV_LSB +: 2]);
      o_buck_b_ov   <= rps_ov_dec(r_thr_b[`RPS_OV_LSB +: 2]);
      o_buck_c_ov   <= rps_ov_dec(r_thr_c[`RPS_OV_LSB +: 2]);
      case (r_freq[`RPS_FREQ_LSB +: 2])
        2'b00:   o_buck_c_freq <= 8'd75;
        2'b01:   o_buck_c_freq <= 8'd100;
        2'b10:   o_buck_c_freq <= 8'd125;
        default: o_buck_c_freq <= 8'd150;
      endcase
      o_buck_a_ilim <= rps_ilim_ab_dec(r_ilim[`RPS_ILIM_A_LSB +: 2]);
      o_buck_b_ilim <= rps_ilim_ab_dec(r_ilim[`RPS_ILIM_B_LSB +: 2]);
      case (r_ilim[`RPS_ILIM_C_LSB +: 2])
        2'b00:   o_buck_c_ilim <= 8'd5;
        2'b01:   o_buck_c_ilim <= 8'd10;
        2'b10:   o_buck_c_ilim <= 8'd15;
        default: o_buck_c_ilim <= 8'd20;
      endcase
      o_ldo_high_volt <= rps_ldo_dec(8'd170, r_ldo[`RPS_LDOH_LSB +: 2]);
      o_ldo_low_volt  <= rps_ldo_dec(8'd90, r_ldo[`RPS_LDOL_LSB +: 2]);
    end
  end
endmodule // rps_sequencer
`default_nettype wire

// ---- verification/rps_sva.sv ----
// port assertions of the sequencer, bound into every instance
`timescale 1ns/10ps
`default_nettype none
module rps_sva #(
  parameter [31:0] P_RELEASE_CYC = 32'd5000
) (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_supply_ok,
  input wire logic       i_enable_pin,
  input wire logic [2:0] i_buck_ok,
  input wire logic       o_power_ok_oe,
  input wire logic       o_ldo_high_en,
  input wire logic       o_ldo_low_en,
  input wire logic [2:0] o_buck_en,
  input wire logic       o_mgmt_ready,
  input wire logic       o_sda_oe,
  input wire logic [7:0] o_buck_c_freq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [31:0] busy_cyc;
  logic [31:0] sup_cyc;
  // cycles since the supply input went high, held once the ready deadline is reached
  always @(posedge i_mclk) begin
    if (i_rst || !i_supply_ok) begin
      sup_cyc <= 32'h0;
    end else if (sup_cyc < 32'h9d8) begin
      sup_cyc <= sup_cyc + 32'h1;
    end
  end
  // rails on while power ok still held low: bounded by the release deadline
  always @(posedge i_mclk) begin
    if (i_rst || !o_power_ok_oe || o_buck_en == 3'b000) begin
      busy_cyc <= 32'h0;
    end else begin
      busy_cyc <= busy_cyc + 32'h1;
    end
  end
  sequence s_sup_up;
    $rose(i_supply_ok) ##1 i_supply_ok [*2];
  endsequence
  sup_gate_a: assert property (!i_supply_ok [*5] |-> !o_power_ok_oe && !o_ldo_high_en)
    else $error("outputs active without supply");
  pok_low_a: assert property (s_sup_up ##1 i_supply_ok [*6]
    |-> o_power_ok_oe && o_ldo_high_en && o_ldo_low_en) else $error("no pok low or ldo");
  mgmt_time_a: assert property ((s_sup_up |-> !o_mgmt_ready)
    and (sup_cyc == 32'h9d8 |-> o_mgmt_ready)) else $error("bus ready timing wrong");
  sda_idle_a: assert property (!o_mgmt_ready |-> !o_sda_oe)
    else $error("bus answered before ready");
  rail_pok_a: assert property ((o_buck_en[2] && !i_buck_ok[2]) [*8] |-> o_power_ok_oe)
    else $error("pok released with bad rail");
  pin_off_a: assert property ($fell(i_enable_pin) && o_buck_en != 3'b000
    |-> ##[1:8] o_buck_en == 3'b000) else $error("pin low left bucks on");
  load_first_a: assert property ($changed(o_buck_c_freq) |-> o_power_ok_oe)
    else $error("settings loaded after release");
  rel_bound_a: assert property (busy_cyc <= P_RELEASE_CYC + 32'd4)
    else $error("release deadline overrun");
endmodule // rps_sva
bind rps_sequencer rps_sva #(.P_RELEASE_CYC(P_RELEASE_CYC)) i_rps_sva (
  .i_mclk, .i_rst, .i_supply_ok, .i_enable_pin, .i_buck_ok, .o_power_ok_oe,
  .o_ldo_high_en, .o_ldo_low_en, .o_buck_en, .o_mgmt_ready, .o_sda_oe, .o_buck_c_freq);
`default_nettype wire

// ---- verification/rps_host_model.sv ----
// host controller: bit-banged management bus master and rail feedback
`timescale 1ns/10ps
`default_nettype none
`include "rps_defines.vh"
module rps_host_model (
  input  wire logic       i_mclk,
  input  wire logic       i_sda,
  input  wire logic [2:0] i_buck_en,
  input  wire logic       i_ldo_en,
  input  wire logic       i_hold,
  output logic            o_scl,
  output logic            o_sda_oe,
  output logic [2:0]      o_buck_ok,
  output logic            o_ldo_ok
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // a held rail never reaches tolerance, which starves the sequencer
  always @(posedge i_mclk) begin
    o_buck_ok <= i_hold ? 3'b000 : i_buck_en;
    o_ldo_ok <= i_ldo_en;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // one bit per 40 clocks, data changed only while the bus clock is low
  task automatic bt(input logic b, output logic s);
    o_scl <= 1'b0;
    w(10);
    o_sda_oe <= ~b;
    w(10);
    o_scl <= 1'b1;
    w(10);
    s = i_sda;
    w(10);
  endtask
  // go high gives a start or repeated start, low gives a stop
  task automatic ed(input logic go);
    o_scl <= 1'b0;
    w(10);
    o_sda_oe <= ~go;
    w(10);
    o_scl <= 1'b1;
    w(20);
    o_sda_oe <= go;
    w(20);
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(1'b1, ak);
    ak = ~ak;
  endtask
  task automatic acc(input logic rd, input logic [7:0] a, d, output logic [7:0] q);
    logic       k;
    logic [7:0] x;
    k = 1'b0;
    for (int n = 0; n < 40 && !k; n++) begin
      ed(1'b1);
      xb({`RPS_I2C_ADDR, 1'b0}, x, k);
      if (k) xb(a, x, k);
      if (k && rd) begin
        ed(1'b1);
        xb({`RPS_I2C_ADDR, 1'b1}, x, k);
        xb(8'hff, q, x[0]);
      end else if (k) xb(d, x, k);
      ed(1'b0);
      if (!k) w(400);
    end
  endtask
endmodule // rps_host_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench: supply ramp, bus set-up, enables, decode and deadline
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       i_mclk, i_rst, i_supply_ok, i_enable_pin, hold;
  wire        sda, scl, h_oe, d_oe, p_oe, ldo_en, ldol_en, ldo_ok, mgmt;
  wire  [2:0] buck_en, buck_ok;
  wire  [7:0] a_uv, b_uv, c_uv, a_ov, b_ov, c_ov, c_fq, a_il, b_il, c_il, lh, ll;
  int         bad_count, total_checks, cyc;
  logic [7:0] q;
  logic [1:0] k;
  logic [8:0] en_log = 9'h0;
  logic [2:0] en_last = 3'h0;
  logic [7:0] uv_t [4] = '{8'h64, 8'h7d, 8'h4b, 8'hc8};
  logic [7:0] ov_t [4] = '{8'h4b, 8'h64, 8'h7d, 8'hc8};
  logic [7:0] fq_t [4] = '{8'h4b, 8'h64, 8'h7d, 8'h96};
  logic [7:0] ia_t [4] = '{8'h32, 8'h37, 8'h3c, 8'h3c};
  logic [7:0] ic_t [4] = '{8'h05, 8'h0a, 8'h0f, 8'h14};
  logic [7:0] lh_t [4] = '{8'haa, 8'hb4, 8'hbe, 8'hc8};
  logic [7:0] ll_t [4] = '{8'h5a, 8'h64, 8'h6e, 8'h78};
  logic [7:0] ra [6] = '{8'h08, 8'h20, 8'h28, 8'h2b, 8'h32, 8'h7f};
  logic [7:0] rv [6] = '{8'h08, 8'h03, 8'h20, 8'h42, 8'h00, 8'h00};
  // the open-drain data wire idles high when neither side pulls it low; the host drives the clock wire directly
  assign sda = ~(h_oe | d_oe);
  rps_sequencer #(.P_RELEASE_CYC(32'd5000), .P_STEP_UNIT_CYC(32'd10)) i_rps_sequencer (
    .i_mclk, .i_rst, .i_supply_ok, .i_enable_pin, .i_power_ok_in(~p_oe), .o_power_ok_out(),
    .o_power_ok_oe(p_oe), .i_scl(scl), .i_sda_in(sda), .o_sda_out(), .o_sda_oe(d_oe),
    .i_ldo_high_ok(ldo_ok), .i_ldo_low_ok(ldo_ok), .i_buck_ok(buck_ok), .o_ldo_high_en(ldo_en),
    .o_ldo_low_en(ldol_en), .o_buck_en(buck_en), .o_mgmt_ready(mgmt), .o_buck_a_uv(a_uv),
    .o_buck_b_uv(b_uv), .o_buck_c_uv(c_uv), .o_buck_a_ov(a_ov), .o_buck_b_ov(b_ov),
    .o_buck_c_ov(c_ov),
    .o_buck_c_freq(c_fq), .o_buck_a_ilim(a_il), .o_buck_b_ilim(b_il), .o_buck_c_ilim(c_il),
    .o_ldo_high_volt(lh), .o_ldo_low_volt(ll));
  rps_host_model i_rps_host_model (.i_mclk, .i_sda(sda), .i_buck_en(buck_en),
    .i_ldo_en(ldo_en), .i_hold(hold), .o_scl(scl), .o_sda_oe(h_oe), .o_buck_ok(buck_ok),
    .o_ldo_ok(ldo_ok));
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (buck_en !== en_last) en_log <= {en_log[5:0], buck_en};
    en_last <= buck_en;
    cyc++;
    if (cyc == 95000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic ck(input logic [7:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic dec(input int u, o, f, ia, ic, h, l);
    ck(a_uv, uv_t[u], "buck a uv");
    ck(b_uv, uv_t[u], "buck b uv");
    ck(c_uv, uv_t[u], "buck c uv");
    ck(c_ov, ov_t[o], "buck c ov");
    ck(a_ov, ov_t[o], "buck a ov");
    ck(b_ov, ov_t[o], "buck b ov");
    ck(c_fq, fq_t[f], "buck c freq");
    ck(c_il, ic_t[ic], "buck c ilim");
    ck(a_il, ia_t[ia], "buck a ilim");
    ck(b_il, ia_t[ia], "buck b ilim");
    ck(lh, lh_t[h], "ldo high");
    ck(ll, ll_t[l], "ldo low");
  endtask
  task automatic settle();
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    i_rst = 1'b1;
    i_supply_ok = 1'b0;
    i_enable_pin = 1'b0;
    hold = 1'b0;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (20) @(posedge i_mclk);
    ck(8'(p_oe | ldo_en), 8'h00, "active before supply");
    dec(0, 2, 0, 0, 3, 1, 1);
    i_supply_ok <= 1'b1;
    wait (mgmt === 1'b1);
    ck(8'({p_oe, ldo_en, ldol_en}), 8'h07, "pok or ldo after supply");
    for (int i = 0; i < 6; i++) begin
      i_rps_host_model.acc(1'b1, ra[i], 8'h00, q);
      ck(q, rv[i], "register reset value");
    end
    $display("power up test done");
    i_rps_host_model.acc(1'b0, 8'h40, 8'h14, q);
    i_rps_host_model.acc(1'b0, 8'h41, 8'h11, q);
    i_rps_host_model.acc(1'b0, 8'h42, 8'h12, q);
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      i_rps_host_model.acc(1'b0, 8'h20, {k, 2'b00, k, k}, q);
      i_rps_host_model.acc(1'b0, 8'h22, {2'b00, k, k, 2'b00}, q);
      i_rps_host_model.acc(1'b0, 8'h26, {2'b00, k, k, 2'b00}, q);
      i_rps_host_model.acc(1'b0, 8'h28, {2'b00, k, k, 2'b00}, q);
      i_rps_host_model.acc(1'b0, 8'h2a, {6'h00, k}, q);
      i_rps_host_model.acc(1'b0, 8'h2b, {k, 3'b000, k, 1'b0}, q);
      i_rps_host_model.acc(1'b0, 8'h32, 8'h80, q);
      wait (p_oe === 1'b0);
      settle();
      ck(en_log[8:1], 8'h97, "buck enable order");
      dec(c, c, c, c, c, c, c);
      i_rps_host_model.acc(1'b1, 8'h08, 8'h00, q);
      ck(q, 8'h2d, "status after release");
      i_rps_host_model.acc(1'b0, 8'h32, 8'h00, q);
      wait (buck_en === 3'b000);
      settle();
      ck(8'(p_oe), 8'h01, "abort keeps pok low");
      $display("decode test %0d done", c);
    end
    @(posedge i_mclk) i_enable_pin <= 1'b1;
    wait (p_oe === 1'b0);
    ck(8'(buck_en), 8'h07, "pin enable");
    @(posedge i_mclk) i_enable_pin <= 1'b0;
    wait (buck_en === 3'b000);
    settle();
    ck(8'(p_oe), 8'h01, "pin disable");
    $display("pin test done");
    hold <= 1'b1;
    i_rps_host_model.acc(1'b0, 8'h32, 8'h80, q);
    // read while busy: refused until the deadline abort, then retried
    i_rps_host_model.acc(1'b1, 8'h08, 8'h00, q);
    wait (buck_en === 3'b000);
    settle();
    ck(8'(p_oe), 8'h01, "pok after deadline");
    ck(q, 8'h0a, "status after deadline");
    $display("deadline test done");
    conclude();
  end
endmodule // tb
`default_nettype wire
